// [rtl/rrx_pkg.sv]
// package for the return, reset and rotate execution block
// assumes one 100 MHz clock, asynchronous active-low reset, APB register access
// Function
// RQ1: software reset pulses device reset and clears reset-instruction flag
// RQ2: return from interrupt pops stack into program counter, two cycles
// RQ3: return from interrupt sets global interrupt enable, bit 7 of interrupt control
// RQ4: return from subroutine pops stack into program counter, two cycles
// RQ5: return with literal loads working register with 8-bit immediate
// RQ6: return with literal pops return address into program counter, two cycles
// RQ7: rotate left: old carry into bit 0, old bit 7 becomes carry
// RQ8: destination bit 0 writes working register, 1 writes back source register
// RQ9: returns and reset leave flags; rotate changes only carry, one cycle
package rrx_pkg;
   // ****************************************************************
   // constants
   // ****************************************************************
   localparam int PROGRAM_COUNTER_W = 13;
   localparam int FADDR_W = 7;
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STAT = 12'h004;
   localparam logic [11:0] ADDR_PROGRAM_COUNTER = 12'h008;
   localparam logic [11:0] ADDR_WREG = 12'h00C;
   localparam int GLOBAL_INTERRUPT_ENABLE_BIT = 7;
   localparam int RESET_INSTRUCTION_FLAG_BIT = 2;
   localparam logic [7:0] INTERRUPT_CONTROL_REGISTER_RST = 8'h00;
   // flag bit starts high so a software reset is visible by its clearing
   localparam logic [7:0] POWER_CONTROL_REGISTER_RST = 8'h0C;
   localparam logic [1:0] RET_CYCLES = 2'h2;

   typedef enum logic [2:0] {
      OP_NONE, OP_SWRESET, OP_RETFROMINT, OP_RETSUB, OP_RETLIT, OP_ROTL
   } op_t;

   // one decoded instruction as presented by the core sequencer
   typedef struct packed {
      logic valid;
      op_t op;
      logic [7:0] literal;
      logic [FADDR_W-1:0] faddr;
      logic dest;
   } instr_t;

   // writeback bundle toward the file register
   typedef struct packed {
      logic we;
      logic [FADDR_W-1:0] addr;
      logic [7:0] data;
   } fwrite_t;
endpackage : rrx_pkg

// [rtl/rotl_unit.sv]
// rotate-left-through-carry datapath
// assumes operands are stable while the instruction executes
`timescale 1ns/1ns
module rotl_unit
   import rrx_pkg::*;
(
   input wire logic [7:0] src,
   input wire logic carry_in,
   output logic [7:0] result,
   output logic carry_out
);
   // bit 7 leaves through carry, carry enters at bit 0
   assign result = {src[6:0], carry_in}; // RQ7
   assign carry_out = src[7]; // RQ7
endmodule : rotl_unit

// [rtl/rrx_exec.sv]
// execution of software reset, returns and rotate left through carry
// assumes the sequencer holds instr until busy drops and supplies stack_top
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ns
module rrx_exec
   import rrx_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire instr_t instr,
   input wire logic [PROGRAM_COUNTER_W-1:0] stack_top,
   input wire logic [7:0] src_data,
   output logic stack_pop,
   output logic [PROGRAM_COUNTER_W-1:0] program_counter,
   output logic [7:0] working_register,
   output logic carry,
   output logic [7:0] interrupt_control_register,
   output logic [7:0] power_control_register,
   output logic device_reset,
   output logic busy,
   output fwrite_t fwrite
);
   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      logic [PROGRAM_COUNTER_W-1:0] program_counter;
      logic [7:0] wreg;
      logic carry;
      logic [7:0] interrupt_control_register;
      logic [7:0] power_control_register;
      logic rst;
      logic pop;
      logic [1:0] cyc;
      logic busy;
      fwrite_t fw;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic [7:0] count;
   } state_t;

   state_t s_q;
   state_t s_d;
   logic [7:0] rot_res;
   logic rot_c;

   rotl_unit u_rot (
      .src(src_data),
      .carry_in(s_q.carry),
      .result(rot_res),
      .carry_out(rot_c)
   );

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      logic acc;
      logic wr;
      acc = psel && !penable;
      wr = psel && penable && s_q.ready && pwrite;
      s_d = s_q;
      s_d.pop = 1'b0;
      s_d.rst = 1'b0;
      s_d.fw.we = 1'b0;
      s_d.ready = 1'b0;
      s_d.err = 1'b0;
      // second cycle of a two-cycle return just releases the core
      if (s_q.busy) begin
         s_d.cyc = s_q.cyc - 2'h1;
         if (s_q.cyc == 2'h1) begin
            s_d.busy = 1'b0;
         end
      end else if (instr.valid) begin
         s_d.count = s_q.count + 8'h01;
         unique case (instr.op)
            OP_SWRESET: begin
               s_d.rst = 1'b1; // RQ1
               s_d.power_control_register[RESET_INSTRUCTION_FLAG_BIT] = 1'b0; // RQ1
            end
            OP_RETFROMINT: begin
               s_d.program_counter = stack_top; // RQ2
               s_d.pop = 1'b1; // RQ2
               s_d.interrupt_control_register[GLOBAL_INTERRUPT_ENABLE_BIT] = 1'b1; // RQ3
               s_d.busy = 1'b1;
               s_d.cyc = RET_CYCLES - 2'h1; // RQ2
            end
            OP_RETSUB: begin
               s_d.program_counter = stack_top; // RQ4
               s_d.pop = 1'b1; // RQ4
               s_d.busy = 1'b1;
               s_d.cyc = RET_CYCLES - 2'h1; // RQ4
            end
            OP_RETLIT: begin
               s_d.wreg = instr.literal; // RQ5
               s_d.program_counter = stack_top; // RQ6
               s_d.pop = 1'b1; // RQ6
               s_d.busy = 1'b1;
               s_d.cyc = RET_CYCLES - 2'h1; // RQ6
            end
            OP_ROTL: begin
               // only carry among the flags moves; done in this one cycle
               s_d.carry = rot_c; // RQ9
               if (instr.dest) begin
                  s_d.fw.we = 1'b1; // RQ8
                  s_d.fw.addr = instr.faddr; // RQ8
                  s_d.fw.data = rot_res; // RQ8
               end else begin
                  s_d.wreg = rot_res; // RQ8
               end
            end
            OP_NONE: begin
               s_d.count = s_q.count;
            end
            default: begin
               s_d.count = s_q.count;
            end
         endcase
      end
      // apb setup: latch read data so that prdata and pready rise together
      if (acc) begin
         s_d.ready = 1'b1;
         unique case (paddr)
            ADDR_CTRL: begin
               s_d.rdata = {15'h0, s_q.carry, s_q.power_control_register,
                  s_q.interrupt_control_register};
            end
            ADDR_STAT: begin
               s_d.rdata = {22'h0, s_q.count, s_q.busy, s_q.rst};
            end
            ADDR_PROGRAM_COUNTER: begin
               s_d.rdata = {{(32-PROGRAM_COUNTER_W){1'b0}}, s_q.program_counter};
            end
            ADDR_WREG: begin
               s_d.rdata = {24'h000000, s_q.wreg};
            end
            default: begin
               s_d.rdata = 32'h00000000;
               s_d.err = 1'b1;
            end
         endcase
      end
      // apb access: a write lands only at the edge where pready is seen high;
      // being last here, it wins over an instruction effect in the same cycle
      if (wr) begin
         unique case (paddr)
            ADDR_CTRL: begin
               s_d.interrupt_control_register = pwdata[7:0];
               s_d.power_control_register = pwdata[15:8];
               s_d.carry = pwdata[16];
            end
            ADDR_PROGRAM_COUNTER: begin
               s_d.program_counter = pwdata[PROGRAM_COUNTER_W-1:0];
            end
            ADDR_WREG: begin
               s_d.wreg = pwdata[7:0];
            end
            default: begin
            end
         endcase
      end
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.interrupt_control_register <= INTERRUPT_CONTROL_REGISTER_RST;
         s_q.power_control_register <= POWER_CONTROL_REGISTER_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // all outputs straight from flops
   assign prdata = s_q.rdata;
   assign pready = s_q.ready;
   assign pslverr = s_q.err;
   assign stack_pop = s_q.pop;
   assign program_counter = s_q.program_counter;
   assign working_register = s_q.wreg;
   assign carry = s_q.carry;
   assign interrupt_control_register = s_q.interrupt_control_register;
   assign power_control_register = s_q.power_control_register;
   assign device_reset = s_q.rst;
   assign busy = s_q.busy;
   assign fwrite = s_q.fw;
endmodule : rrx_exec

// [verification/rrx_exec_asserts.sv]
// checker for the return, reset and rotate execution block
// assumes it is bound to rrx_exec and sees its ports only
`timescale 1ns/1ns
module rrx_exec_asserts
   import rrx_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire instr_t instr,
   input wire logic [PROGRAM_COUNTER_W-1:0] stack_top,
   input wire logic [7:0] src_data,
   input wire logic stack_pop,
   input wire logic [PROGRAM_COUNTER_W-1:0] program_counter,
   input wire logic [7:0] working_register,
   input wire logic carry,
   input wire logic [7:0] interrupt_control_register,
   input wire logic [7:0] power_control_register,
   input wire logic device_reset,
   input wire logic busy,
   input wire fwrite_t fwrite
);
   // ******
   // helpers
   // ******
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire tk = instr.valid && !busy; // instruction taken at this edge
   wire ret = tk && instr.op inside {OP_RETFROMINT, OP_RETSUB, OP_RETLIT};
   wire rot = tk && instr.op == OP_ROTL;
   logic [8:0] rq_q;
   // operand snapshot, so the expected rotate result needs no part-select of $past
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) rq_q <= '0;
      else rq_q <= {src_data, carry};
   end
   // ******
   // properties
   // ******
   a_sw_reset: assert property (tk && instr.op == OP_SWRESET |=> device_reset && !power_control_register[RESET_INSTRUCTION_FLAG_BIT]) else $error("software reset effect missing");
   a_ret_pop: assert property (ret |=> stack_pop && program_counter == $past(stack_top)) else $error("return did not pop stack into program counter");
   a_int_enable_set: assert property (tk && instr.op == OP_RETFROMINT |=> interrupt_control_register[GLOBAL_INTERRUPT_ENABLE_BIT]) else $error("interrupt enable not set");
   a_ret_two: assert property (ret |=> busy ##1 !busy && !stack_pop) else $error("return not two cycles");
   a_lit_load: assert property (tk && instr.op == OP_RETLIT |=> working_register == $past(instr.literal)) else $error("literal not loaded");
   a_ret_flags: assert property (ret |=> $stable(carry)) else $error("return changed carry");
   a_rot_carry: assert property (rot |=> carry == rq_q[8] && !busy) else $error("rotate carry wrong");
   a_rot_wreg: assert property (rot && !instr.dest |=> working_register == rq_q[7:0] && !fwrite.we) else $error("rotate to wreg wrong");
   a_rot_file: assert property (rot && instr.dest |=> fwrite.we && fwrite.addr == $past(instr.faddr) && fwrite.data == rq_q[7:0]) else $error("rotate writeback wrong");
   c_ret: cover property (ret);
   c_rot_file: cover property (rot && instr.dest);
   c_reset: cover property (tk && instr.op == OP_SWRESET);
endmodule : rrx_exec_asserts
bind rrx_exec rrx_exec_asserts chk_u (.pclk, .presetn, .instr, .stack_top, .src_data, .stack_pop, .program_counter, .working_register, .carry, .interrupt_control_register, .power_control_register, .device_reset, .busy, .fwrite);

// [verification/rrx_exec_tb_top.sv]
// bench for rrx_exec: apb accesses and instruction sequences
// assumes rrx_pkg and the checker are compiled before it
`timescale 1ns/1ns
module rrx_exec_tb_top;
   import rrx_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, stack_pop, carry, device_reset, busy, err, pop_s, rst_s, bsy_s;
   logic [PROGRAM_COUNTER_W-1:0] stack_top = '0, program_counter;
   logic [7:0] src_data = '0, working_register, interrupt_control_register;
   logic [7:0] power_control_register;
   instr_t instr = '0;
   fwrite_t fwrite, fw_s;
   int failures = 0, n_compared = 0;
   rrx_exec dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
      .pready, .pslverr, .instr, .stack_top, .src_data, .stack_pop, .program_counter,
      .working_register, .carry, .interrupt_control_register, .power_control_register,
      .device_reset, .busy, .fwrite);
   // ******
   // tasks
   // ******
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic summarize();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : summarize
   // one apb transfer; an edge first so release and next setup never share a step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 8; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      chk(pready, 1'b1);
      if (pready !== 1'b1) summarize();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // one instruction; pulses are snapshot in the cycle after the taking edge
   task automatic exec(input op_t op, input logic [7:0] lit, input logic d,
      input logic [PROGRAM_COUNTER_W-1:0] top, input logic [7:0] src);
      int i;
      @(posedge pclk);
      instr <= '{1'b1, op, lit, 7'h7F, d};
      stack_top <= top;
      src_data <= src;
      @(posedge pclk);
      instr.valid <= 1'b0;
      #1;
      pop_s = stack_pop;
      rst_s = device_reset;
      bsy_s = busy;
      fw_s = fwrite;
      for (i = 0; i < 4 && busy !== 1'b0; i++) begin
         @(posedge pclk);
         #1;
      end
      if (busy !== 1'b0) chk(busy, 1'b0);
      if (busy !== 1'b0) summarize();
   endtask : exec
   // ******
   // stimulus
   // ******
   initial begin
      forever #5 pclk = ~pclk;
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      chk(power_control_register, POWER_CONTROL_REGISTER_RST);
      chk(interrupt_control_register, INTERRUPT_CONTROL_REGISTER_RST);
      exec(OP_SWRESET, 8'h00, 1'b0, 13'h0000, 8'h00);
      chk(rst_s, 1'b1);
      chk(power_control_register[RESET_INSTRUCTION_FLAG_BIT], 1'b0);
      exec(OP_RETFROMINT, 8'h00, 1'b0, 13'h1ABC, 8'h00);
      chk({pop_s, bsy_s, program_counter}, {2'b11, 13'h1ABC});
      chk(interrupt_control_register[GLOBAL_INTERRUPT_ENABLE_BIT], 1'b1);
      // carry set first, so a return that disturbed the flag would show
      apb(1'b1, ADDR_CTRL, 32'h00010880);
      // plain return, then literal returns at both ends of the literal range
      for (int k = 0; k < 3; k++) begin
         exec(k ? OP_RETLIT : OP_RETSUB, k == 1 ? 8'hFF : 8'h00, 1'b0, 13'h0123 << k, 8'h00);
         chk({pop_s, bsy_s, program_counter}, {2'b11, 13'h0123 << k});
         chk(carry, 1'b1);
         if (k > 0) chk(working_register, k == 1 ? 8'hFF : 8'h00);
      end
      // carry in high: 1110 0110 gives 1100 1101 and carry out high
      exec(OP_ROTL, 8'h00, 1'b0, 13'h0000, 8'hE6);
      chk({carry, working_register}, 9'h1CD);
      chk({bsy_s, fw_s.we}, 2'b00);
      exec(OP_ROTL, 8'h00, 1'b1, 13'h0000, 8'h01);
      chk(fw_s, {1'b1, 7'h7F, 8'h03});
      chk({carry, working_register}, 9'h0CD);
      // carry in low: 1110 0110 gives 1100 1100 and carry out high
      exec(OP_ROTL, 8'h00, 1'b0, 13'h0000, 8'hE6);
      chk({carry, working_register}, 9'h1CC);
      apb(1'b1, ADDR_WREG, 32'h0000005A);
      apb(1'b0, ADDR_WREG, 32'h00000000);
      chk(rd, 32'h0000005A);
      chk(working_register, 8'h5A);
      apb(1'b1, ADDR_PROGRAM_COUNTER, 32'h00000ABC);
      apb(1'b0, ADDR_PROGRAM_COUNTER, 32'h00000000);
      chk(rd, 32'h00000ABC);
      chk(program_counter, 13'h0ABC);
      // eight instructions taken so far, count sits above busy and reset bits
      apb(1'b0, ADDR_STAT, 32'h00000000);
      chk(rd, 32'h00000020);
      apb(1'b0, ADDR_CTRL, 32'h00000000);
      chk(rd, 32'h00010880);
      apb(1'b0, 12'h010, 32'h00000000);
      chk({err, rd[7:0]}, 9'h100);
      summarize();
   end
endmodule : rrx_exec_tb_top
